// >>> rtl/sice_defines.svh
/*
  Constants for the serial in-system programming command engine:
  opcodes, second-byte selectors, memory geometry and wait times.
  Assumes inclusion by bare name from the package and design modules.
*/
`ifndef SICE_DEFINES_SVH
`define SICE_DEFINES_SVH

// Opcodes (first instruction byte)
`define SICE_OP_ENABLE      8'hAC
`define SICE_OP_POLL        8'hF0
`define SICE_OP_LD_EXT      8'h4D
`define SICE_OP_LD_PG_HI    8'h48
`define SICE_OP_LD_PG_LO    8'h40
`define SICE_OP_LD_EE_PG    8'hC1
`define SICE_OP_RD_PG_HI    8'h28
`define SICE_OP_RD_PG_LO    8'h20
`define SICE_OP_RD_EE       8'hA0
`define SICE_OP_RD_LOCK_FH  8'h58
`define SICE_OP_RD_FL_XF    8'h50
`define SICE_OP_RD_SIG      8'h30
`define SICE_OP_RD_CAL      8'h38
`define SICE_OP_WR_PG       8'h4C
`define SICE_OP_WR_EE       8'hC0
`define SICE_OP_WR_EE_PG    8'hC2
// Second-byte selectors
`define SICE_B2_ENABLE      8'h53
`define SICE_B2_ERASE       8'h80
`define SICE_B2_WR_LOCK     8'hE0
`define SICE_B2_WR_FUSE_LO  8'hA0
`define SICE_B2_WR_FUSE_HI  8'hA8
`define SICE_B2_WR_FUSE_EX  8'hA4
`define SICE_B2_HI_SEL      8'h08
// Geometry: 4 KiB flash = 2048 words, 64-byte EEPROM
`define SICE_FLASH_WORDS    2048
`define SICE_EE_BYTES       64
`define SICE_ERASED         8'hFF
// Wait times in microseconds and the 40 MHz clock in MHz
`define SICE_CLK_MHZ        40
`define SICE_T_FLASH_US     4500
`define SICE_T_EEPROM_US    4000
`define SICE_T_ERASE_US     4000
`define SICE_T_FUSE_US      4500
`define SICE_CYC_FLASH      (`SICE_T_FLASH_US * `SICE_CLK_MHZ)
`define SICE_CYC_EEPROM     (`SICE_T_EEPROM_US * `SICE_CLK_MHZ)
`define SICE_CYC_ERASE      (`SICE_T_ERASE_US * `SICE_CLK_MHZ)
`define SICE_CYC_FUSE       (`SICE_T_FUSE_US * `SICE_CLK_MHZ)

`endif

// >>> rtl/sice_pkg.sv
/*
  Types for the serial programming command engine.
  Assumes the defines header sits beside it.
*/
package sice_pkg;
  `include "sice_defines.svh"

  // Kind of pending self-timed operation
  typedef enum logic [2:0] {
    SICE_OP_NONE,
    SICE_OP_FLASH,
    SICE_OP_EEBYTE,
    SICE_OP_EEPAGE,
    SICE_OP_ERASE,
    SICE_OP_FUSE
  } sice_wr_t;
endpackage : sice_pkg

// >>> rtl/sice_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
module sice_fifo #(
  parameter int WIDTH = 32,   // Word width
  parameter int DEPTH = 4     // Number of words
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // Storage
  logic [AW-1:0]    wr_ptr;       // Next slot to fill
  logic [AW-1:0]    rd_ptr;       // Next slot to drain
  logic [AW:0]      count;        // Words held
  logic             push;
  logic             pop;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write; no reset needed for data
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap modulo depth
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  // Occupancy
  always_ff @(posedge core_clk) begin
    if (rst) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + 1'b1;
    end else if (pop && !push) begin
      count <= count - 1'b1;
    end
  end
endmodule : sice_fifo

// >>> rtl/sice_link.sv
/*
  Serial link front end: synchronises the serial clock, data-in and
  reset pins, finds serial clock edges, and shifts bytes MSB first.
  Assumes the serial clock phases each last more than two core clocks.
*/
module sice_link (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Pins from the programmer
  input  wire logic       sck_pin,
  input  wire logic       mosi_pin,
  input  wire logic       reset_n_pin,
  // Outgoing byte, loaded at the byte boundary
  input  wire logic [7:0] tx_byte,
  // Decoded link state
  output logic            prog_active,
  output logic            rise,
  output logic            fall,
  output logic            bit_in,
  output logic            byte_done,
  output logic      [7:0] rx_byte,
  output logic            miso_out
);
  logic [1:0] sck_s;    // Serial clock synchroniser
  logic [1:0] mosi_s;   // Data-in synchroniser
  logic [1:0] rstn_s;   // Reset pin synchroniser
  logic       sck_d;    // Previous synchronised serial clock
  logic [2:0] bit_cnt;  // Bits taken in the current byte
  logic [7:0] shift_in; // Incoming shifter
  logic [7:0] shift_out;// Outgoing shifter

  // Two-stage synchronisers; only the second stage is read
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sck_s  <= '0;
      mosi_s <= '0;
      rstn_s <= 2'h3;
    end else begin
      sck_s  <= {sck_s[0], sck_pin};
      mosi_s <= {mosi_s[0], mosi_pin};
      rstn_s <= {rstn_s[0], reset_n_pin};
    end
  end

  // Edge detector runs off the second stage only
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sck_d <= 1'b0;
    end else begin
      sck_d <= sck_s[1];
    end
  end

  assign prog_active = !rstn_s[1];
  assign rise        = prog_active && sck_s[1] && !sck_d;
  assign fall        = prog_active && !sck_s[1] && sck_d;
  assign bit_in      = mosi_s[1];
  assign byte_done   = rise && (bit_cnt == 3'h7);
  assign rx_byte     = {shift_in[6:0], mosi_s[1]};

  // Input shifter, MSB first, sampled on serial clock rise
  always_ff @(posedge core_clk) begin
    if (rst || !prog_active) begin
      bit_cnt  <= '0;
      shift_in <= '0;
    end else if (rise) begin
      bit_cnt  <= bit_cnt + 3'h1;
      shift_in <= {shift_in[6:0], mosi_s[1]};
    end
  end

  // Output shifter: new byte at the boundary, next bit on each fall except the first one after it
  always_ff @(posedge core_clk) begin
    if (rst || !prog_active) begin
      shift_out <= '0;
      miso_out  <= 1'b0;
    end else if (byte_done) begin
      shift_out <= {tx_byte[6:0], 1'b0};
      miso_out  <= tx_byte[7];
    end else if (fall && bit_cnt != 3'h0) begin
      miso_out  <= shift_out[7];
      shift_out <= {shift_out[6:0], 1'b0};
    end
  end
endmodule : sice_link

// >>> rtl/sice_engine.sv
/*
  Serial in-system programming command engine: frames four-byte
  instructions from the link, queues them in a small FIFO, executes
  them against flash, EEPROM, fuse and lock storage, and times the
  self-timed writes. Assumes pins arrive asynchronously to core_clk.
*/
// Function
// - Programming only while reset pin is low
// - Reject program/erase until enable completes
// - EEPROM write self-erases target first
// - Chip erase sets flash and EEPROM to ones
// - Sample on rise, drive out on fall; each outgoing byte's MSB is driven on the rise ending the byte before
// - Echo 0x53 during third byte when synced
// - Page buffer loaded by five low address bits
// - Page write commits buffer to upper-bit page
// - EEPROM byte write at third-byte address
// - EEPROM page load and commit, loaded bytes only
// - Poll returns busy in bit zero
// - Reads return flash bytes and EEPROM byte
// - Reads return lock, fuses, signature, calibration
// - Writes to lock and fuse bytes
// - Load extended address byte accepted
// - Reset release ends programming session
`include "sice_defines.svh"

module sice_engine
  import sice_pkg::*;
#(
  parameter int CYC_FLASH  = `SICE_CYC_FLASH,   // Flash page write time
  parameter int CYC_EEPROM = `SICE_CYC_EEPROM,  // EEPROM write time
  parameter int CYC_ERASE  = `SICE_CYC_ERASE,   // Chip erase time
  parameter int CYC_FUSE   = `SICE_CYC_FUSE,    // Fuse or lock write time
  parameter logic [7:0] SIG0 = 8'h1E,           // Signature bytes, arbitrary values
  parameter logic [7:0] SIG1 = 8'h55,
  parameter logic [7:0] SIG2 = 8'h0C,
  parameter logic [7:0] CAL  = 8'h80            // Calibration byte
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Serial programming pins
  input  wire logic sck_pin,
  input  wire logic mosi_pin,
  input  wire logic reset_n_pin,
  output logic      miso_out,
  output logic      miso_oe,
  // Status
  output logic      prog_enabled,
  output logic      write_pending_flag
);
  localparam int FW = $clog2(`SICE_FLASH_WORDS);
  localparam int EW = $clog2(`SICE_EE_BYTES);

  // Storage arrays
  logic [15:0] flash_mem [`SICE_FLASH_WORDS];   // Program memory words
  logic [7:0]  ee_mem    [`SICE_EE_BYTES];      // EEPROM bytes
  logic [15:0] pg_buf    [32];                  // Flash page buffer
  logic [7:0]  ee_buf    [4];                   // EEPROM page buffer
  logic [3:0]  ee_loaded;                       // EEPROM buffer slots loaded
  logic [7:0]  fuse_lo, fuse_hi, fuse_ex, lock_bits;
  logic [7:0]  ext_addr;                        // Extended address byte

  // Link signals
  logic        active, rise, fall, bit_in, byte_done;
  logic [7:0]  rx_byte, tx_byte;
  logic        miso_raw;
  logic [1:0]  byte_idx;                        // Byte within instruction
  logic [23:0] hdr;                             // First three bytes
  logic [7:0]  b1, b2, b3;
  logic        active_d;

  // FIFO between framing and execution
  logic        q_in_valid, q_in_ready, q_out_valid, q_out_ready;
  logic [31:0] q_out_data;
  logic [7:0]  c1, c2, c3, c4;

  // Self-timed write state
  sice_wr_t    wr_kind;
  logic [31:0] wr_cnt;
  logic [5:0]  wr_page;                         // Flash page: 64 pages of 32 words
  logic [3:0]  wr_eepage;
  logic [EW-1:0] wr_ee_addr;
  logic [7:0]  wr_ee_data;
  logic [11:0] erase_idx;                       // Sweep index for erase

  sice_link u_link (
    .core_clk    (core_clk),
    .rst         (rst),
    .sck_pin     (sck_pin),
    .mosi_pin    (mosi_pin),
    .reset_n_pin (reset_n_pin),
    .tx_byte     (tx_byte),
    .prog_active (active),
    .rise        (rise),
    .fall        (fall),
    .bit_in      (bit_in),
    .byte_done   (byte_done),
    .rx_byte     (rx_byte),
    .miso_out    (miso_raw)
  );

  // Link drives data out only during a session
  assign miso_out = miso_raw;
  assign miso_oe  = active;

  assign b1 = hdr[23:16];
  assign b2 = hdr[15:8];
  assign b3 = hdr[7:0];

  // Byte framing; the session ending clears the byte index and header
  always_ff @(posedge core_clk) begin
    if (rst || !active) begin
      byte_idx <= '0;
      hdr      <= '0;
    end else if (byte_done) begin
      byte_idx <= byte_idx + 2'h1;
      if (byte_idx != 2'h3) begin
        hdr <= {hdr[15:0], rx_byte};
      end
    end
  end

  // Read lookup, used for the answer byte
  function automatic logic [7:0] read_byte(input logic [7:0] op, input logic [7:0] a2,
                                           input logic [7:0] a3);
    logic [FW-1:0] wa;
    wa = FW'({a2, a3});
    case (op)
      `SICE_OP_RD_PG_HI:   read_byte = flash_mem[wa][15:8];
      `SICE_OP_RD_PG_LO:   read_byte = flash_mem[wa][7:0];
      `SICE_OP_RD_EE:      read_byte = ee_mem[a3[EW-1:0]];
      `SICE_OP_RD_LOCK_FH: read_byte = (a2 == `SICE_B2_HI_SEL) ? fuse_hi : lock_bits;
      `SICE_OP_RD_FL_XF:   read_byte = (a2 == `SICE_B2_HI_SEL) ? fuse_ex : fuse_lo;
      `SICE_OP_RD_SIG:     read_byte = (a3[1:0] == 2'h0) ? SIG0 :
                                       (a3[1:0] == 2'h1) ? SIG1 : SIG2;
      `SICE_OP_RD_CAL:     read_byte = CAL;
      `SICE_OP_POLL:       read_byte = {7'h00, write_pending_flag};
      default:             read_byte = 8'h00;
    endcase
  endfunction : read_byte

  // Outgoing byte chosen at each boundary and shown during the next
  // byte: echo of the byte just taken during bytes 2 and 3, the
  // answer during byte 4, zero during the next instruction's byte 1
  always_comb begin
    tx_byte = 8'h00;
    if (byte_idx == 2'h2) begin
      tx_byte = read_byte(hdr[15:8], hdr[7:0], rx_byte);
    end else if (byte_idx != 2'h3) begin
      tx_byte = rx_byte;
    end
  end

  // Completed instruction pushed on the last byte
  assign q_in_valid = byte_done && (byte_idx == 2'h3);

  sice_fifo #(
    .WIDTH (32),
    .DEPTH (4)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst || !active),
    .in_valid  (q_in_valid),
    .in_ready  (q_in_ready),
    .in_data   ({hdr, rx_byte}),
    .out_valid (q_out_valid),
    .out_ready (q_out_ready),
    .out_data  (q_out_data)
  );

  assign {c1, c2, c3, c4} = q_out_data;
  // Execution stalls while a self-timed write runs
  assign q_out_ready = (wr_kind == SICE_OP_NONE);

  // Session state: enable flag set by the enable instruction
  always_ff @(posedge core_clk) begin
    if (rst || !active) begin
      prog_enabled <= 1'b0;
      active_d     <= 1'b0;
    end else begin
      active_d <= active;
      if (q_out_valid && q_out_ready && c1 == `SICE_OP_ENABLE
          && c2 == `SICE_B2_ENABLE) begin
        prog_enabled <= 1'b1;
      end
    end
  end

  assign write_pending_flag = (wr_kind != SICE_OP_NONE);

  // Execute instructions and run the self-timed writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_kind    <= SICE_OP_NONE;
      wr_cnt     <= '0;
      ext_addr   <= '0;
      ee_loaded  <= '0;
      wr_page    <= '0;
      wr_eepage  <= '0;
      wr_ee_addr <= '0;
      wr_ee_data <= '0;
      erase_idx  <= '0;
      fuse_lo    <= 8'hFF;
      fuse_hi    <= 8'hFF;
      fuse_ex    <= 8'hFF;
      lock_bits  <= 8'hFF;
    end else if (wr_kind != SICE_OP_NONE) begin
      // Flash and EEPROM writes commit on the final count, when busy drops; erase sweeps while busy; fuse and lock change as busy rises
      if (wr_kind == SICE_OP_ERASE && erase_idx != 12'(`SICE_FLASH_WORDS)) begin
        flash_mem[erase_idx[FW-1:0]] <= {`SICE_ERASED, `SICE_ERASED};
        if (erase_idx < 12'(`SICE_EE_BYTES)) begin
          ee_mem[erase_idx[EW-1:0]] <= `SICE_ERASED;
        end
        erase_idx <= erase_idx + 12'h1;
      end
      if (wr_cnt > 32'h1) begin
        wr_cnt <= wr_cnt - 32'h1;
      end else begin
        case (wr_kind)
          SICE_OP_FLASH: begin
            for (int i = 0; i < 32; i++) begin
              flash_mem[{wr_page, 5'(i)}] <= pg_buf[i];
            end
          end
          SICE_OP_EEBYTE: begin
            ee_mem[wr_ee_addr] <= wr_ee_data;
          end
          SICE_OP_EEPAGE: begin
            for (int i = 0; i < 4; i++) begin
              if (ee_loaded[i]) begin
                ee_mem[{wr_eepage, 2'(i)}] <= ee_buf[i];
              end
            end
            ee_loaded <= '0;
          end
          default: ;
        endcase
        wr_kind <= SICE_OP_NONE;
      end
    end else if (q_out_valid && prog_enabled) begin
      case (c1)
        `SICE_OP_LD_EXT: ext_addr <= c3;
        `SICE_OP_LD_PG_LO: pg_buf[c3[4:0]][7:0]  <= c4;
        `SICE_OP_LD_PG_HI: pg_buf[c3[4:0]][15:8] <= c4;
        `SICE_OP_LD_EE_PG: begin
          ee_buf[c3[1:0]]    <= c4;
          ee_loaded[c3[1:0]] <= 1'b1;
        end
        `SICE_OP_WR_PG: begin
          wr_page <= {c2[2:0], c3[7:5]};
          wr_kind <= SICE_OP_FLASH;
          wr_cnt  <= 32'(CYC_FLASH);
        end
        `SICE_OP_WR_EE: begin
          wr_ee_addr <= c3[EW-1:0];
          wr_ee_data <= c4;
          wr_kind    <= SICE_OP_EEBYTE;
          wr_cnt     <= 32'(CYC_EEPROM);
        end
        `SICE_OP_WR_EE_PG: begin
          wr_eepage <= c3[5:2];
          wr_kind   <= SICE_OP_EEPAGE;
          wr_cnt    <= 32'(CYC_EEPROM);
        end
        `SICE_OP_ENABLE: begin
          case (c2)
            `SICE_B2_ERASE: begin
              erase_idx <= '0;
              lock_bits <= 8'hFF;
              wr_kind   <= SICE_OP_ERASE;
              wr_cnt    <= 32'(CYC_ERASE);
            end
            `SICE_B2_WR_LOCK: begin
              lock_bits <= c4;
              wr_kind   <= SICE_OP_FUSE;
              wr_cnt    <= 32'(CYC_FUSE);
            end
            `SICE_B2_WR_FUSE_LO: begin
              fuse_lo <= c4;
              wr_kind <= SICE_OP_FUSE;
              wr_cnt  <= 32'(CYC_FUSE);
            end
            `SICE_B2_WR_FUSE_HI: begin
              fuse_hi <= c4;
              wr_kind <= SICE_OP_FUSE;
              wr_cnt  <= 32'(CYC_FUSE);
            end
            `SICE_B2_WR_FUSE_EX: begin
              fuse_ex <= c4;
              wr_kind <= SICE_OP_FUSE;
              wr_cnt  <= 32'(CYC_FUSE);
            end
            default: ;
          endcase
        end
        default: ;
      endcase
    end
  end
endmodule : sice_engine

// >>> bench/sice_engine_properties.sv
/*
  Concurrent checks on the serial programming engine's ports.
  Assumes one core_clk domain and the engine's write-time parameters.
*/
module sice_engine_checker
  import sice_pkg::*;
#(
  parameter int CYC_EEPROM = 50,    // Shortest self-timed write
  parameter int CYC_ERASE  = 2100   // Longest self-timed write
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Serial pins
  input wire logic sck_pin,
  input wire logic mosi_pin,
  input wire logic reset_n_pin,
  input wire logic miso_out,
  input wire logic miso_oe,
  // Status
  input wire logic prog_enabled,
  input wire logic write_pending_flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic [15:0] pend_cnt;  // Cycles the current write has pended
  logic [3:0]  quiet;     // Cycles since the serial clock moved
  logic        sck_q;     // Serial clock one cycle ago

  // Saturating length of the current pending stretch
  always_ff @(posedge core_clk) begin
    if (rst || !write_pending_flag) begin
      pend_cnt <= 16'h0000;
    end else if (pend_cnt != 16'hFFFF) begin
      pend_cnt <= pend_cnt + 16'h0001;
    end
  end

  // Saturates so that a long idle gap never wraps back to small
  always_ff @(posedge core_clk) begin
    sck_q <= sck_pin;
    if (rst || sck_q != sck_pin) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hF) begin
      quiet <= quiet + 4'h1;
    end
  end

  // Pin held long enough to pass the synchroniser
  sequence pin_low6;
    !reset_n_pin [*6];
  endsequence
  sequence pin_high6;
    reset_n_pin [*6];
  endsequence

  oe_in_session_a: assert property (pin_low6 |-> miso_oe)
    else $error("serial output off during session");
  oe_off_idle_a: assert property (pin_high6 |-> !miso_oe)
    else $error("serial output on outside session");
  session_end_a: assert property (pin_high6 |-> !prog_enabled)
    else $error("enable kept after session end");
  enable_held_a: assert property (pin_low6 ##0 prog_enabled |=> prog_enabled)
    else $error("enable lost inside session");
  enable_in_session_a: assert property ($rose(prog_enabled) |-> miso_oe && !reset_n_pin)
    else $error("enable rose outside session");
  write_needs_enable_a: assert property ($rose(write_pending_flag) |-> prog_enabled)
    else $error("write started before enable");
  pend_min_a: assert property ($fell(write_pending_flag) |-> int'(pend_cnt) + 2 >= CYC_EEPROM)
    else $error("self-timed write too short");
  pend_max_a: assert property (write_pending_flag |-> int'(pend_cnt) <= CYC_ERASE + 2)
    else $error("self-timed write too long");
  miso_quiet_a: assert property (miso_oe && $past(miso_oe) && $changed(miso_out)
                                 |-> quiet <= 4'h8)
    else $error("serial output moved with clock idle");
endmodule : sice_engine_checker

bind sice_engine sice_engine_checker #(
  .CYC_EEPROM (CYC_EEPROM),
  .CYC_ERASE  (CYC_ERASE)
) u_checker (
  .core_clk           (core_clk),
  .rst                (rst),
  .sck_pin            (sck_pin),
  .mosi_pin           (mosi_pin),
  .reset_n_pin        (reset_n_pin),
  .miso_out           (miso_out),
  .miso_oe            (miso_oe),
  .prog_enabled       (prog_enabled),
  .write_pending_flag (write_pending_flag)
);

// >>> bench/sice_programmer.sv
/*
  Behavioural in-system programmer driving the serial pins.
  Assumes the bench's core_clk; all pin moves land 2 ns after its edge.
*/
module sice_programmer #(
  parameter int HALF       = 4,   // Core clocks per serial clock phase
  parameter int ENTRY_WAIT = 40   // Shortened wait before enable
) (
  // Reference clock and returned data
  input  wire logic core_clk,
  input  wire logic miso_out,
  // Pins driven into the engine
  output logic      sck_pin,
  output logic      mosi_pin,
  output logic      reset_n_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle: out of session, clock low
  initial begin
    sck_pin = 1'b0;
    mosi_pin = 1'b0;
    reset_n_pin = 1'b1;
  end

  // Wait n edges, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : tick

  // Four bytes, MSB first; data moves on fall, read on rise
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    for (int i = 31; i >= 0; i--) begin
      mosi_pin = tx[i];
      tick(HALF);
      rx = {rx[30:0], miso_out};
      sck_pin = 1'b1;
      tick(HALF);
      sck_pin = 1'b0;
    end
    tick(1);
    mosi_pin = ~mosi_pin; // Stale level is not kept after a frame
  endtask : xfer

  // Clock low, reset pulsed high, then the entry wait
  task automatic open_session();
    sck_pin = 1'b0;
    reset_n_pin = 1'b1;
    tick(2);
    reset_n_pin = 1'b0;
    tick(ENTRY_WAIT);
  endtask : open_session

  // Enable with one resync attempt on a wrong echo
  task automatic enter(output logic [31:0] rx);
    open_session();
    xfer(32'hAC530000, rx);
    if (rx[15:8] !== 8'h53) begin
      open_session();
      xfer(32'hAC530000, rx);
    end
  endtask : enter

  // Release reset to end the session
  task automatic leave();
    reset_n_pin = 1'b1;
    tick(8);
  endtask : leave
endmodule : sice_programmer

// >>> bench/tb_serial_isp_command_engine.sv
/*
  Self-checking bench for the serial programming engine.
  Assumes the programmer model in sice_programmer and the bound checker.
*/
module tb_serial_isp_command_engine;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int         CYC_W = 600;   // Long enough for a busy poll
  localparam int         CYC_E = 2100;  // Erase must cover every word
  localparam logic [7:0] S0    = 8'h3C; // Signature, arbitrary values
  localparam logic [7:0] S1    = 8'h96;
  localparam logic [7:0] S2    = 8'h0F;
  localparam logic [7:0] CL    = 8'h71; // Calibration, arbitrary value
  localparam int         NR    = 35;    // Rows: kind, answer, instruction
  // Kind 0 sends only, 1 checks byte 4, 2 writes then polls
  localparam logic [41:0] ROWS [NR] = '{
    {2'h2, 8'h00, 32'hAC800000},
    {2'h1, 8'hFF, 32'hA0000500},
    {2'h1, 8'hFF, 32'h28000300},
    {2'h0, 8'h00, 32'h400003A5},
    {2'h0, 8'h00, 32'h4800035A},
    {2'h2, 8'h00, 32'h4C000000},
    {2'h1, 8'hA5, 32'h20000300},
    {2'h1, 8'h5A, 32'h28000300},
    {2'h1, 8'hFF, 32'h20002300},
    {2'h0, 8'h00, 32'h400063C3},
    {2'h2, 8'h00, 32'h4C006000},
    {2'h1, 8'hC3, 32'h20006300},
    {2'h1, 8'hA5, 32'h20000300},
    {2'h2, 8'h00, 32'hC0000512},
    {2'h2, 8'h00, 32'hC0000521},
    {2'h1, 8'h21, 32'hA0000500},
    {2'h0, 8'h00, 32'hC1000177},
    {2'h2, 8'h00, 32'hC2000400},
    {2'h1, 8'h77, 32'hA0000500},
    {2'h1, 8'hFF, 32'hA0000600},
    {2'h1, 8'hFF, 32'hA0000400},
    {2'h2, 8'h00, 32'hACA000E2},
    {2'h1, 8'hE2, 32'h50000000},
    {2'h2, 8'h00, 32'hACA800DF},
    {2'h1, 8'hDF, 32'h58080000},
    {2'h2, 8'h00, 32'hACA400FE},
    {2'h1, 8'hFE, 32'h50080000},
    {2'h1, S0,    32'h30000000},
    {2'h1, S1,    32'h30000100},
    {2'h1, S2,    32'h30000200},
    {2'h1, CL,    32'h38000000},
    {2'h0, 8'h00, 32'h4D000000},
    {2'h1, 8'hA5, 32'h20000300},
    {2'h2, 8'h00, 32'hACE000FC},  // Lock last: it may gate later reads
    {2'h1, 8'hFC, 32'h58000000}
  };

  logic        core_clk;           // 40 MHz core clock
  logic        rst;                // Synchronous reset
  logic        sck_pin;            // Pins from the programmer
  logic        mosi_pin;
  logic        reset_n_pin;
  logic        miso_out;           // Pins and status from the engine
  logic        miso_oe;
  logic        prog_enabled;
  logic        write_pending_flag;
  logic [31:0] rx;                 // Bytes returned by the last frame
  int          n_errors;
  int          comparisons;

  always #12.5 core_clk = ~core_clk;

  sice_engine #(
    .CYC_FLASH  (CYC_W),
    .CYC_EEPROM (CYC_W),
    .CYC_ERASE  (CYC_E),
    .CYC_FUSE   (CYC_W),
    .SIG0       (S0),
    .SIG1       (S1),
    .SIG2       (S2),
    .CAL        (CL)
  ) u_dut (
    .core_clk           (core_clk),
    .rst                (rst),
    .sck_pin            (sck_pin),
    .mosi_pin           (mosi_pin),
    .reset_n_pin        (reset_n_pin),
    .miso_out           (miso_out),
    .miso_oe            (miso_oe),
    .prog_enabled       (prog_enabled),
    .write_pending_flag (write_pending_flag)
  );

  sice_programmer u_prog (
    .core_clk    (core_clk),
    .miso_out    (miso_out),
    .sck_pin     (sck_pin),
    .mosi_pin    (mosi_pin),
    .reset_n_pin (reset_n_pin)
  );

  // Counts, verdict and the single end of the run
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask : cmp_bit

  // Poll until idle; a stuck busy bit ends the run
  task automatic poll_idle();
    int i;
    for (i = 0; i < 20; i++) begin
      u_prog.xfer(32'hF0000000, rx);
      if (rx[0] === 1'b0) break;
    end
    if (i == 20) begin
      n_errors++;
      $display("mismatch at %0t: busy never cleared", $time);
      report_and_stop();
    end
  endtask : poll_idle

  // Main sequence
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    n_errors = 0;
    comparisons = 0;
    repeat (16) @(posedge core_clk);
    #2;
    rst = 1'b0;
    cmp_bit(prog_enabled, 1'b0, "enable after reset");
    cmp_bit(miso_oe, 1'b0, "oe after reset");
    u_prog.enter(rx);
    u_prog.tick(8);
    cmp_byte(rx[23:16], 8'hAC, "echo of byte 1");
    cmp_byte(rx[15:8], 8'h53, "echo of byte 2");
    cmp_bit(prog_enabled, 1'b1, "enable after entry");
    $display("test entry done");
    for (int r = 0; r < NR; r++) begin
      u_prog.xfer(ROWS[r][31:0], rx);
      if (ROWS[r][41:40] == 2'h1) cmp_byte(rx[7:0], ROWS[r][39:32], "answer");
      if (ROWS[r][41:40] == 2'h2) begin
        u_prog.xfer(32'hF0000000, rx);
        cmp_bit(rx[0], 1'b1, "busy during write");
        poll_idle();
      end
    end
    u_prog.xfer(32'hF0000000, rx);
    cmp_byte(rx[7:0], 8'h00, "idle poll");
    $display("test rows done");
    u_prog.leave();
    cmp_bit(prog_enabled, 1'b0, "enable after release");
    cmp_bit(miso_oe, 1'b0, "oe after release");
    $display("test release done");
    // A write in a fresh session without enable must not start
    u_prog.open_session();
    u_prog.xfer(32'hC0000534, rx);
    u_prog.tick(8);
    cmp_bit(write_pending_flag, 1'b0, "write before enable");
    u_prog.enter(rx);
    u_prog.tick(8);
    cmp_bit(prog_enabled, 1'b1, "enable on re-entry");
    u_prog.xfer(32'h50000000, rx);
    cmp_byte(rx[7:0], 8'hE2, "fuse kept across sessions");
    $display("test re-entry done");
    report_and_stop();
  end
endmodule : tb_serial_isp_command_engine
